// ---- src/lpc_defines.vh ----
// Purpose: Shared constants for the DDR2 low-power state controller.
// Assumes: REF_CLK at 250 MHz; command bits packed as {cs_n, ras_n, cas_n, we_n}.
// Notes:   Timing counts in CK clocks unless the name says NS or REFI; LPC_CK_HALF_DEF counts REF_CLK cycles.
`ifndef LPC_DEFINES_VH
`define LPC_DEFINES_VH

// ****************************************************************
// Command encodings {cs_n, ras_n, cas_n, we_n}
// ****************************************************************
`define LPC_CMD_NOP     4'h7
`define LPC_CMD_DESEL   4'hF
`define LPC_CMD_SRE     4'h1
`define LPC_CMD_REF     4'h1
`define LPC_CMD_READ    4'h5
`define LPC_CMD_RD_MASK 4'hD

// ****************************************************************
// Timing figures
// ****************************************************************
`define LPC_REF_CLK_NS  4
`define LPC_TXSRD_CK    8'hC8
`define LPC_CKE_MIN_CK  8'h03
`define LPC_FRQ_WAIT_CK 8'h02
`define LPC_TREFI_NS    7800
`define LPC_PD_MAX_REFI 9
`define LPC_TDELAY_NS   20
`define LPC_CK_HALF_DEF 8'h14

`endif

// ---- src/lpc_ckgen.v ----
// Purpose: Divides REF_CLK down to the DDR2 CK/CK_N pair.
// Assumes: half >= 1; the clock stops only in its low phase.
// Notes:   rise/fall pulse in the REF_CLK cycle before CK changes.
`timescale 1ns/1ns
`include "lpc_defines.vh"

module lpc_ckgen (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Control
  input  wire       run,
  input  wire [7:0] half,
  // Outputs
  output reg        ck,
  output reg        ck_n,
  output wire       rise,
  output wire       fall
);

  reg  [7:0] div_r;   // REF_CLK cycles into current half period
  wire       hit;     // Half period complete
  wire       tog;     // CK toggles this cycle

  assign hit  = (div_r >= half - 8'h01);
  // Stop is only honoured while CK is low, so no runt high pulse appears
  assign tog  = hit & (ck | run);
  assign rise = tog & ~ck;
  assign fall = tog & ck;

  // ****************************************************************
  // Divider
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= 8'h00;
      ck    <= 1'b0;
      ck_n  <= 1'b1;
    end else if (tog) begin
      div_r <= 8'h00;
      ck    <= ~ck;
      ck_n  <= ck;
    end else if (!hit) begin
      div_r <= div_r + 8'h01;
    end
  end

endmodule // lpc_ckgen

// ---- src/lpc_ctrl.v ----
// Purpose: Host-side DDR2 low-power control: self refresh, power-down,
//          clock frequency change and asynchronous CKE drop recovery.
// Assumes: User side on REF_CLK; CK generated here by a divider.
// Notes:   Pins change on the REF_CLK edge where CK falls, start of low phase; ASYNC_FAULT in S_IDLE drops CKE and ODT at once.
// What this block does
// - Self refresh entry: CS RAS CAS CKE low
// - ODT off tAOFD before entry, until tXSRD
// - Hold CKE low to stay in self refresh
// - Stay in self refresh at least tCKE
// - Clock may stop after entry, restart first
// - Read after tXSRD, others after tXSNR
// - Only NOP during self refresh exit
// - CKE high and ODT off throughout tXSRD
// - Auto refresh needed before self refresh re-entry
// - Self refresh only with all banks idle
// - Power-down: CKE low with NOP, not busy
// - Power-down: tCKE low, ODT valid, 9 tREFI max
// - Exit with NOP, then wait exit latency
// - Unlocked DLL entry needs DLL reset later
// - Async CKE drop: tDelay, clock, full reinit
// - Frequency change in precharge power-down, two clocks
// - Stable clock, DLL reset, ODT off until relock; ODT follows ODT_REQ after the change until exit sets DLL_RESET_REQ
// - tXSRD equals 200 clocks
// - CKE high and low three clocks minimum
`timescale 1ns/1ns
`include "lpc_defines.vh"

module lpc_ctrl #(
  parameter [7:0] TAOFD_CK  = 8'h03,   // ODT off lead before entry
  parameter [7:0] TCKE_CK   = 8'h03,   // CKE minimum pulse, CK clocks
  parameter [7:0] TXSNR_CK  = 8'h20,   // Self refresh exit, non-read
  parameter [7:0] TXP_CK    = 8'h06,   // Power-down exit latency
  parameter [7:0] STABLE_CK = 8'h10,   // Clock settle after restart
  parameter       PDW       = 16,      // Power-down timer width
  parameter [PDW-1:0] PD_MAX_CYC = `LPC_PD_MAX_REFI * `LPC_TREFI_NS / `LPC_REF_CLK_NS
) (
  // Clock and reset
  input  wire       REF_CLK,
  input  wire       RST,
  // User requests
  input  wire       SR_REQ,
  input  wire       PD_REQ,
  input  wire       EXIT_REQ,
  input  wire       CLK_STOP_REQ,
  input  wire       FREQ_REQ,
  input  wire [7:0] FREQ_HALF,
  input  wire       ASYNC_FAULT,
  input  wire       REINIT_ACK,
  // Memory-side state reported by the outer controller
  input  wire       BANKS_IDLE,
  input  wire       BUSY,
  input  wire       DLL_LOCKED,
  // Pass-through command
  input  wire       USR_VALID,
  input  wire [3:0] USR_CMD,
  input  wire       ODT_REQ,
  output wire       USR_READY,
  // Status
  output reg        IN_SR,
  output reg        IN_PD,
  output reg        PRE_PD,
  output reg        READ_OK,
  output reg        REF_NEEDED,
  output reg        DLL_RESET_REQ,
  output reg        REINIT_REQ,
  output reg        PD_TIMEOUT,
  // DDR2 pins
  output wire       CK,
  output wire       CK_N,
  output reg        CKE,
  output reg        CS_N,
  output reg        RAS_N,
  output reg        CAS_N,
  output reg        WE_N,
  output reg        ODT
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [3:0] S_IDLE   = 4'h0;  // Normal, CKE high
  localparam [3:0] S_ODTOFF = 4'h1;  // ODT low lead before entry
  localparam [3:0] S_SRHOLD = 4'h2;  // In self refresh
  localparam [3:0] S_SRSTOP = 4'h3;  // Self refresh, clock stopped
  localparam [3:0] S_SRWARM = 4'h4;  // Self refresh, clock settling
  localparam [3:0] S_SREXIT = 4'h5;  // Exit interval, NOP only
  localparam [3:0] S_PDHOLD = 4'h6;  // In power-down
  localparam [3:0] S_PDEXIT = 4'h7;  // Power-down exit latency
  localparam [3:0] S_FRSTOP = 4'h8;  // Frequency change, clock stopped
  localparam [3:0] S_FRWARM = 4'h9;  // New clock settling
  localparam [3:0] S_ASDLY  = 4'hA;  // tDelay after CKE drop
  localparam [3:0] S_ASSTOP = 4'hB;  // Clock off after CKE drop
  localparam [3:0] S_ASWARM = 4'hC;  // Clock restored, CKE still low

  localparam [7:0] TDLY_CYC =
    (`LPC_TDELAY_NS + `LPC_REF_CLK_NS - 1) / `LPC_REF_CLK_NS;

  // Larger of two counts; used for the power-down hold and exit counts
  function [7:0] lpc_max8;
    input [7:0] a;
    input [7:0] b;
    begin
      lpc_max8 = (a > b) ? a : b;
    end
  endfunction

  localparam [7:0] HOLD_CK = (TCKE_CK > `LPC_CKE_MIN_CK) ? TCKE_CK : `LPC_CKE_MIN_CK;

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [3:0]     state_r;    // Controller state
  reg  [7:0]     cnt_r;      // Remaining CK clocks (REF cycles in S_ASDLY)
  reg  [7:0]     xs_r;       // CK clocks since self refresh exit
  reg  [PDW-1:0] pd_tmr_r;   // REF cycles spent in power-down
  reg  [1:0]     hi_r;       // CKE high clocks, saturating
  reg  [1:0]     lo_r;       // CKE low clocks, saturating
  reg            run_r;      // CK divider running
  reg  [7:0]     half_r;     // CK half period in REF cycles
  reg            frq_r;      // A frequency change happened
  wire           rise;       // CK rising this cycle
  wire           fall;       // CK falling; pins update now
  wire           can_enter;  // Low-power entry allowed

  assign USR_READY = (state_r == S_IDLE) & fall & ~SR_REQ & ~PD_REQ & ~ASYNC_FAULT;
  // Entry needs CKE high three clocks and no mode, read or write busy
  assign can_enter = (hi_r == 2'h3) & ~BUSY & ~ASYNC_FAULT;

  // ****************************************************************
  // CK generator
  // ****************************************************************
  lpc_ckgen lpc_ckgen_inst (
    .clk  (REF_CLK),
    .rst  (RST),
    .run  (run_r),
    .half (half_r),
    .ck   (CK),
    .ck_n (CK_N),
    .rise (rise),
    .fall (fall)
  );

  // Drives the command pins with the given code
  task put_cmd;
    input [3:0] c;
    begin
      {CS_N, RAS_N, CAS_N, WE_N} <= c;
    end
  endtask

  // ****************************************************************
  // CKE residency counters, counted on CK edges
  // ****************************************************************
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      hi_r <= 2'h0;
      lo_r <= 2'h0;
    end else if (rise) begin
      if (CKE) begin
        lo_r <= 2'h0;
        hi_r <= (hi_r == 2'h3) ? hi_r : hi_r + 2'h1;
      end else begin
        hi_r <= 2'h0;
        lo_r <= (lo_r == 2'h3) ? lo_r : lo_r + 2'h1;
      end
    end
  end

  // ****************************************************************
  // Main state machine
  // ****************************************************************
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_r       <= S_IDLE;
      cnt_r         <= 8'h00;
      xs_r          <= 8'h00;
      pd_tmr_r      <= {PDW{1'b0}};
      run_r         <= 1'b1;
      half_r        <= `LPC_CK_HALF_DEF;
      frq_r         <= 1'b0;
      CKE           <= 1'b1;
      {CS_N, RAS_N, CAS_N, WE_N} <= `LPC_CMD_NOP;
      ODT           <= 1'b0;
      IN_SR         <= 1'b0;
      IN_PD         <= 1'b0;
      PRE_PD        <= 1'b0;
      READ_OK       <= 1'b1;
      REF_NEEDED    <= 1'b0;
      DLL_RESET_REQ <= 1'b0;
      REINIT_REQ    <= 1'b0;
      PD_TIMEOUT    <= 1'b0;
    end else begin
      // Acknowledges; a new request in the same cycle wins below
      if (REINIT_ACK) begin
        REINIT_REQ <= 1'b0;
      end
      if (DLL_LOCKED) begin
        DLL_RESET_REQ <= 1'b0;
      end
      case (state_r)
        S_IDLE: begin
          if (ASYNC_FAULT) begin
            // CKE dropped outside any protocol; report and recover
            CKE     <= 1'b0;
            ODT     <= 1'b0;
            cnt_r   <= TDLY_CYC;
            state_r <= S_ASDLY;
          end else if (fall) begin
            put_cmd(`LPC_CMD_NOP);
            // Termination stays off while the DLL relocks
            ODT <= ODT_REQ & ~DLL_RESET_REQ & READ_OK;
            if (SR_REQ & BANKS_IDLE & ~REF_NEEDED & can_enter) begin
              ODT     <= 1'b0;
              cnt_r   <= TAOFD_CK;
              state_r <= S_ODTOFF;
            end else if (PD_REQ & can_enter) begin
              CKE      <= 1'b0;
              put_cmd(`LPC_CMD_NOP);
              PRE_PD   <= BANKS_IDLE;
              IN_PD    <= 1'b1;
              PD_TIMEOUT <= 1'b0;
              // Entering without lock means a DLL reset afterwards
              if (!DLL_LOCKED) begin
                DLL_RESET_REQ <= 1'b1;
              end
              pd_tmr_r <= {PDW{1'b0}};
              cnt_r    <= lpc_max8(HOLD_CK, `LPC_FRQ_WAIT_CK);
              state_r  <= S_PDHOLD;
            end else if (USR_VALID & ~SR_REQ & ~PD_REQ) begin
              put_cmd(USR_CMD);
              if (USR_CMD == `LPC_CMD_REF) begin
                REF_NEEDED <= 1'b0;
              end
            end
          end
        end
        S_ODTOFF: begin
          if (fall) begin
            if (cnt_r != 8'h00) begin
              cnt_r <= cnt_r - 8'h01;
            end else begin
              CKE     <= 1'b0;
              put_cmd(`LPC_CMD_SRE);
              IN_SR   <= 1'b1;
              cnt_r   <= HOLD_CK;
              state_r <= S_SRHOLD;
            end
          end
        end
        S_SRHOLD: begin
          if (fall) begin
            // Inputs other than CKE are ignored; park on deselect
            put_cmd(`LPC_CMD_DESEL);
            if (cnt_r != 8'h00) begin
              cnt_r <= cnt_r - 8'h01;
            end else if (CLK_STOP_REQ) begin
              run_r   <= 1'b0;
              state_r <= S_SRSTOP;
            end else if (EXIT_REQ) begin
              CKE        <= 1'b1;
              put_cmd(`LPC_CMD_NOP);
              IN_SR      <= 1'b0;
              READ_OK    <= 1'b0;
              REF_NEEDED <= 1'b1;
              xs_r       <= 8'h00;
              state_r    <= S_SREXIT;
            end
          end
        end
        S_SRSTOP: begin
          // Clock is stopped; step on REF_CLK alone
          if (!CLK_STOP_REQ) begin
            run_r   <= 1'b1;
            cnt_r   <= STABLE_CK;
            state_r <= S_SRWARM;
          end
        end
        S_SRWARM: begin
          if (fall) begin
            if (cnt_r != 8'h00) begin
              cnt_r <= cnt_r - 8'h01;
            end else begin
              state_r <= S_SRHOLD;
            end
          end
        end
        S_SREXIT: begin
          if (fall) begin
            // NOP on every edge, CKE high, ODT low, whole interval
            put_cmd(`LPC_CMD_NOP);
            ODT  <= 1'b0;
            xs_r <= xs_r + 8'h01;
            if (xs_r + 8'h01 >= `LPC_TXSRD_CK) begin
              READ_OK <= 1'b1;
            end
            if ((xs_r + 8'h01 >= `LPC_TXSRD_CK) && (xs_r + 8'h01 >= TXSNR_CK)) begin
              state_r <= S_IDLE;
            end
          end
        end
        S_PDHOLD: begin
          // Refresh budget runs in REF cycles, held during a frequency change
          if (pd_tmr_r != PD_MAX_CYC) begin
            pd_tmr_r <= pd_tmr_r + {{(PDW-1){1'b0}}, 1'b1};
          end
          if (fall) begin
            put_cmd(`LPC_CMD_NOP);
            ODT <= ODT_REQ & ~FREQ_REQ & ~DLL_RESET_REQ;
            if (cnt_r != 8'h00) begin
              cnt_r <= cnt_r - 8'h01;
            end else if (pd_tmr_r == PD_MAX_CYC || EXIT_REQ) begin
              PD_TIMEOUT <= (pd_tmr_r == PD_MAX_CYC);
              CKE     <= 1'b1;
              cnt_r   <= lpc_max8(TXP_CK, HOLD_CK);
              state_r <= S_PDEXIT;
            end else if (FREQ_REQ & PRE_PD & ~ODT) begin
              run_r   <= 1'b0;
              state_r <= S_FRSTOP;
            end
          end
        end
        S_FRSTOP: begin
          // Divisor only changes while CK is parked low
          half_r <= (FREQ_HALF == 8'h00) ? 8'h01 : FREQ_HALF;
          if (!FREQ_REQ) begin
            run_r   <= 1'b1;
            frq_r   <= 1'b1;
            cnt_r   <= STABLE_CK;
            state_r <= S_FRWARM;
          end
        end
        S_FRWARM: begin
          if (fall) begin
            if (cnt_r != 8'h00) begin
              cnt_r <= cnt_r - 8'h01;
            end else begin
              state_r <= S_PDHOLD;
            end
          end
        end
        S_PDEXIT: begin
          if (fall) begin
            put_cmd(`LPC_CMD_NOP);
            IN_PD <= 1'b0;
            if (cnt_r != 8'h00) begin
              cnt_r <= cnt_r - 8'h01;
            end else begin
              if (frq_r) begin
                DLL_RESET_REQ <= 1'b1;
              end
              frq_r   <= 1'b0;
              PRE_PD  <= 1'b0;
              state_r <= S_IDLE;
            end
          end
        end
        S_ASDLY: begin
          if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            run_r   <= 1'b0;
            state_r <= S_ASSTOP;
          end
        end
        S_ASSTOP: begin
          if (!ASYNC_FAULT) begin
            run_r   <= 1'b1;
            cnt_r   <= STABLE_CK;
            state_r <= S_ASWARM;
          end
        end
        S_ASWARM: begin
          if (fall) begin
            put_cmd(`LPC_CMD_NOP);
            if (cnt_r != 8'h00) begin
              cnt_r <= cnt_r - 8'h01;
            end else if (lo_r == 2'h3) begin
              CKE        <= 1'b1;
              REINIT_REQ <= 1'b1;
              state_r    <= S_IDLE;
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule // lpc_ctrl

// ---- testbench/lpc_ctrl_monitor.sv ----
// Purpose: Port-level timing checks on the low-power controller.
// Assumes: CK edges are found by sampling CK on REF_CLK.
// Notes:   Run counters count CK rises, not REF cycles.
`timescale 1ns/1ns
module lpc_ctrl_monitor #(
  parameter [7:0]     TAOFD_CK   = 8'h03,
  parameter           PDW        = 16,
  parameter [PDW-1:0] PD_MAX_CYC = 16'h00C8
) (
  // Clock and reset
  input wire REF_CLK,
  input wire RST,
  // Status
  input wire IN_SR,
  input wire IN_PD,
  input wire READ_OK,
  // DDR2 pins
  input wire CK,
  input wire CKE,
  input wire CS_N,
  input wire RAS_N,
  input wire CAS_N,
  input wire WE_N,
  input wire ODT
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  reg         ck_d_r;                  // CK one REF cycle ago
  reg         cke_l_r;                 // CKE at the last CK rise
  reg [7:0]   run_r;                   // Rises at the present CKE level
  reg [7:0]   odtl_r;                  // Rises with ODT low
  reg [8:0]   xs_r;                    // Rises while READ_OK is low
  reg [PDW:0] pd_r;                    // REF cycles powered down
  wire        rise = CK & ~ck_d_r;     // One REF cycle after CK rises
  wire [3:0]  cmd  = {CS_N, RAS_N, CAS_N, WE_N};
  wire        nop  = CS_N | (cmd == 4'h7);
  wire        flip = rise & (CKE != cke_l_r);
  // Run and ODT-low counters saturate so a long idle stretch never wraps to a short run
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ck_d_r  <= 1'b0;
      cke_l_r <= 1'b1;
      run_r   <= 8'h00;
      odtl_r  <= 8'h00;
      xs_r    <= 9'h000;
      pd_r    <= {(PDW+1){1'b0}};
    end else begin
      ck_d_r <= CK;
      pd_r   <= (IN_PD & ~CKE) ? pd_r + 1'b1 : {(PDW+1){1'b0}};
      if (rise) begin
        cke_l_r <= CKE;
        run_r   <= flip ? 8'h01 : run_r + {7'h00, run_r != 8'hFF};
        odtl_r  <= ODT ? 8'h00 : odtl_r + {7'h00, odtl_r != 8'hFF};
        xs_r    <= READ_OK ? 9'h000 : xs_r + 9'h001;
      end
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking mon_cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  cke_low_min_a: assert property (
    flip & CKE |-> run_r >= 8'h03) else $error("CKE low run too short");
  cke_high_min_a: assert property (
    flip & ~CKE |-> run_r >= 8'h03) else $error("CKE high run too short");
  entry_cmd_a: assert property (
    flip & ~CKE |-> nop | (cmd == 4'h1)) else $error("Bad command at CKE fall");
  exit_cmd_a: assert property (
    flip & CKE |-> nop) else $error("Bad command at CKE rise");
  sre_odt_a: assert property (
    flip & ~CKE & (cmd == 4'h1) |-> ~ODT && odtl_r >= TAOFD_CK)
    else $error("Termination on too late before self refresh");
  sr_hold_a: assert property (
    $rose(IN_SR) |-> ~CKE & ~ODT ##1 ~CKE [*7]) else $error("CKE left low state early");
  xs_quiet_a: assert property (
    rise & ~READ_OK |-> nop & CKE & ~ODT) else $error("Exit interval not quiet");
  xs_len_a: assert property (
    $rose(READ_OK) |-> xs_r >= 9'h0C8) else $error("Read allowed too early");
  pd_len_a: assert property (
    pd_r <= {1'b0, PD_MAX_CYC} + 8'h50) else $error("Power-down held too long");
endmodule // lpc_ctrl_monitor

// ---- testbench/lpc_dram_model.sv ----
// Purpose: Behavioural DDR2 device seen through its command pins.
// Assumes: Commands registered at CK rises; no bank tracking.
// Notes:   Counts protocol errors instead of stopping the run.
`timescale 1ns/1ns
module lpc_dram_model (
  // Command pins
  input wire CK,
  input wire CKE,
  input wire CS_N,
  input wire RAS_N,
  input wire CAS_N,
  input wire WE_N,
  input wire ODT,
  // Observations
  output integer err_cnt,
  output integer sr_cnt,
  output integer ref_cnt
);
  reg [2:0]  st     = 3'h0;  // 0 idle 1 SR 2 PD 3 SR exit 4 PD exit
  reg        cke_p  = 1'b1;  // CKE at the previous rise
  reg        dll_on = 1'b1;  // Delay-locked loop running
  integer    cnt    = 0;     // Rises spent in the present state
  wire [3:0] cmd = {CS_N, RAS_N, CAS_N, WE_N};
  wire       nop = CS_N | (cmd == 4'h7);
  initial begin
    err_cnt = 0;
    sr_cnt  = 0;
    ref_cnt = 0;
  end
  // Device state walk; a stopped clock simply freezes it
  always @(posedge CK) begin
    cke_p <= CKE;
    case (st)
      3'h0: begin
        if (cke_p & ~CKE & (cmd == 4'h1)) begin
          st     <= 3'h1;
          cnt    <= 0;
          dll_on <= 1'b0;
          sr_cnt <= sr_cnt + 1;
          if (ODT) err_cnt <= err_cnt + 1;
        end else if (cke_p & ~CKE) begin
          st     <= 3'h2;
          cnt    <= 0;
          dll_on <= 1'b0;
          if (!nop) err_cnt <= err_cnt + 1;
        end else if (CKE & (cmd == 4'h1)) begin
          ref_cnt <= ref_cnt + 1;
        end
      end
      // Only CKE counts in self refresh; residency of three rises
      3'h1: if (CKE) begin
        if (!nop || cnt < 2) err_cnt <= err_cnt + 1;
        st     <= 3'h3;
        dll_on <= 1'b1;
        cnt    <= 0;
      end else cnt <= cnt + 1;
      3'h2: if (CKE) begin
        if (!nop || cnt < 2) err_cnt <= err_cnt + 1;
        st     <= 3'h4;
        dll_on <= 1'b1;
        cnt    <= 0;
      end else cnt <= cnt + 1;
      3'h3: begin
        if (!nop || !CKE || ODT) err_cnt <= err_cnt + 1;
        cnt <= cnt + 1;
        if (cnt == 198) st <= 3'h0;
      end
      default: begin
        if (!nop) err_cnt <= err_cnt + 1;
        cnt <= cnt + 1;
        if (cnt == 2) st <= 3'h0;
      end
    endcase
  end
endmodule // lpc_dram_model

// ---- testbench/lpc_ctrl_tb_top.sv ----
// Purpose: Directed tests of the low-power controller against a device model.
// Assumes: Inputs change at REF_CLK falling edges; CK half period 20.
// Notes:   PD limit shortened to 1024 REF cycles to keep runs short.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
  end \
end
`define WT(c, n) for (wi = 0; wi < (n) && !(c); wi++) @(negedge REF_CLK);
module lpc_ctrl_tb_top;
  reg REF_CLK = 0, RST = 1, SR_REQ = 0, PD_REQ = 0, EXIT_REQ = 0;
  reg CLK_STOP_REQ = 0, FREQ_REQ = 0, ASYNC_FAULT = 0, REINIT_ACK = 0;
  reg BANKS_IDLE = 1, BUSY = 0, DLL_LOCKED = 1, USR_VALID = 0, ODT_REQ = 0;
  reg [7:0] FREQ_HALF = 8'h14;
  reg [3:0] USR_CMD = 4'h7;
  wire USR_READY, IN_SR, IN_PD, PRE_PD, READ_OK, REF_NEEDED, DLL_RESET_REQ;
  wire REINIT_REQ, PD_TIMEOUT, CK, CK_N, CKE, CS_N, RAS_N, CAS_N, WE_N, ODT;
  integer n_fail = 0, checked = 0, cyc = 0, wi, t, chg, err_cnt, sr_cnt, ref_cnt;
  always #2 REF_CLK = ~REF_CLK;
  lpc_ctrl #(.PD_MAX_CYC(16'h0400)) lpc_ctrl_inst (.REF_CLK(REF_CLK), .RST(RST),
    .SR_REQ(SR_REQ), .PD_REQ(PD_REQ), .EXIT_REQ(EXIT_REQ), .CLK_STOP_REQ(CLK_STOP_REQ),
    .FREQ_REQ(FREQ_REQ), .FREQ_HALF(FREQ_HALF), .ASYNC_FAULT(ASYNC_FAULT),
    .REINIT_ACK(REINIT_ACK), .BANKS_IDLE(BANKS_IDLE), .BUSY(BUSY), .DLL_LOCKED(DLL_LOCKED),
    .USR_VALID(USR_VALID), .USR_CMD(USR_CMD), .ODT_REQ(ODT_REQ), .USR_READY(USR_READY),
    .IN_SR(IN_SR), .IN_PD(IN_PD), .PRE_PD(PRE_PD), .READ_OK(READ_OK),
    .REF_NEEDED(REF_NEEDED), .DLL_RESET_REQ(DLL_RESET_REQ), .REINIT_REQ(REINIT_REQ),
    .PD_TIMEOUT(PD_TIMEOUT), .CK(CK), .CK_N(CK_N), .CKE(CKE), .CS_N(CS_N),
    .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .ODT(ODT));
  lpc_dram_model lpc_dram_model_inst (.CK(CK), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N),
    .CAS_N(CAS_N), .WE_N(WE_N), .ODT(ODT), .err_cnt(err_cnt), .sr_cnt(sr_cnt),
    .ref_cnt(ref_cnt));
  // Counts REF cycles with CK off its start level over a stretch where the clock should stand still
  task ck_still;
    begin
      t = CK;
      chg = 0;
      repeat (200) begin
        @(negedge REF_CLK);
        if (CK !== t[0]) chg++;
      end
    end
  endtask
  task t_refuse;
    begin
      BANKS_IDLE = 0;
      SR_REQ = 1;
      repeat (400) @(negedge REF_CLK);
      `CHK("sr_refused", 1'b0, IN_SR)
      SR_REQ = 0;
      BANKS_IDLE = 1;
      BUSY = 1;
      PD_REQ = 1;
      repeat (400) @(negedge REF_CLK);
      `CHK("pd_refused", 1'b1, CKE)
      PD_REQ = 0;
      BUSY = 0;
      $display("t_refuse done");
    end
  endtask
  task t_pd;
    begin
      ODT_REQ = 1;
      PD_REQ = 1;
      `WT(IN_PD, 2000)
      `CHK("pd_cke", 1'b0, CKE)
      `CHK("pd_pre", 1'b1, PRE_PD)
      PD_REQ = 0;
      EXIT_REQ = 1;
      for (t = 0; t < 2000 && !CKE; t++) @(negedge REF_CLK);
      `CHK("pd_low_min", 1'b1, t >= 120)
      EXIT_REQ = 0;
      `WT(!IN_PD, 500)
      BANKS_IDLE = 0;
      PD_REQ = 1;
      `WT(IN_PD, 2000)
      `CHK("pd_active", 1'b0, PRE_PD)
      `WT(PD_TIMEOUT, 1500)
      `CHK("pd_timeout", 1'b1, PD_TIMEOUT)
      PD_REQ = 0;
      BANKS_IDLE = 1;
      `WT(!IN_PD, 500)
      `CHK("pd_out_cke", 1'b1, CKE)
      $display("t_pd done");
    end
  endtask
  // Leaves self refresh and times the exit interval in REF cycles
  task sr_exit;
    begin
      EXIT_REQ = 1;
      `WT(CKE, 3000)
      EXIT_REQ = 0;
      `CHK("xs_read_ok", 1'b0, READ_OK)
      `CHK("xs_ref_need", 1'b1, REF_NEEDED)
      for (t = 0; t < 9000 && !READ_OK; t++) @(negedge REF_CLK);
      `CHK("xs_length", 8000, t)
    end
  endtask
  task t_sr;
    begin
      ODT_REQ = 1;
      SR_REQ = 1;
      `WT(IN_SR, 2000)
      `CHK("sr_in", 1'b1, IN_SR)
      `CHK("sr_odt", 1'b0, ODT)
      SR_REQ = 0;
      CLK_STOP_REQ = 1;
      repeat (200) @(negedge REF_CLK);
      ck_still;
      `CHK("sr_ck_stop", 0, chg)
      CLK_STOP_REQ = 0;
      sr_exit;
      SR_REQ = 1;
      repeat (400) @(negedge REF_CLK);
      `CHK("sr_reentry", 1'b0, IN_SR)
      SR_REQ = 0;
      USR_CMD = 4'h1;
      USR_VALID = 1;
      `WT(USR_READY, 2000)
      @(negedge REF_CLK);
      USR_VALID = 0;
      USR_CMD = 4'h7;
      SR_REQ = 1;
      `WT(IN_SR, 3000)
      `CHK("sr_ref_seen", 1, ref_cnt)
      `CHK("sr_again", 1'b1, IN_SR)
      SR_REQ = 0;
      repeat (200) @(negedge REF_CLK);
      sr_exit;
      `CHK("sr_count", 2, sr_cnt)
      $display("t_sr done");
    end
  endtask
  task t_async;
    begin
      ASYNC_FAULT = 1;
      repeat (3) @(negedge REF_CLK);
      `CHK("af_cke", 1'b0, CKE)
      `CHK("af_odt", 1'b0, ODT)
      repeat (100) @(negedge REF_CLK);
      ck_still;
      `CHK("af_ck_stop", 0, chg)
      ASYNC_FAULT = 0;
      `WT(REINIT_REQ, 3000)
      `CHK("af_reinit", 1'b1, REINIT_REQ)
      `CHK("af_cke_up", 1'b1, CKE)
      REINIT_ACK = 1;
      @(negedge REF_CLK);
      REINIT_ACK = 0;
      @(negedge REF_CLK);
      `CHK("af_ack", 1'b0, REINIT_REQ)
      $display("t_async done");
    end
  endtask
  task t_freq;
    begin
      DLL_LOCKED = 0;
      FREQ_HALF = 8'h0A;
      PD_REQ = 1;
      `WT(IN_PD, 2000)
      FREQ_REQ = 1;
      repeat (400) @(negedge REF_CLK);
      FREQ_REQ = 0;
      PD_REQ = 0;
      EXIT_REQ = 1;
      `WT(!IN_PD, 2000)
      EXIT_REQ = 0;
      `CHK("fq_dll_rst", 1'b1, DLL_RESET_REQ)
      `CHK("fq_odt_off", 1'b0, ODT)
      `WT(CK, 100)
      `WT(!CK, 100)
      for (t = 0; t < 100 && !CK; t++) @(negedge REF_CLK);
      `CHK("fq_half", 10, t)
      `CHK("fq_ck_n", 1'b0, CK_N)
      DLL_LOCKED = 1;
      repeat (2) @(negedge REF_CLK);
      `CHK("fq_relock", 1'b0, DLL_RESET_REQ)
      $display("t_freq done");
    end
  endtask
  task finish_test;
    begin
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // Cuts a hang short well beyond the expected run of about 25000 cycles
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      finish_test;
    end
  end
  initial begin
    repeat (16) @(posedge REF_CLK);
    @(negedge REF_CLK);
    RST = 0;
    `CHK("rst_cke", 1'b1, CKE)
    `CHK("rst_cmd", 4'h7, {CS_N, RAS_N, CAS_N, WE_N})
    repeat (100) @(negedge REF_CLK);
    t_refuse;
    t_pd;
    t_sr;
    t_async;
    t_freq;
    `CHK("model_errors", 0, err_cnt)
    finish_test;
  end
endmodule // lpc_ctrl_tb_top
bind lpc_ctrl lpc_ctrl_monitor #(.TAOFD_CK(TAOFD_CK), .PDW(PDW), .PD_MAX_CYC(PD_MAX_CYC))
  lpc_ctrl_monitor_inst (.REF_CLK(REF_CLK), .RST(RST), .IN_SR(IN_SR), .IN_PD(IN_PD),
  .READ_OK(READ_OK), .CK(CK), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N),
  .WE_N(WE_N), .ODT(ODT));
